/* File: sfcd_decoder.sv */
// Setting-command decoder of a serial flash, with an APB window
// Assumes serial clock well below CLK/4, mode 0 framing, pins async
//
// Notes on behaviour
// - opcode 06 sets write permission latch
// - opcode 04 clears write permission latch
// - opcode 05 streams status register out
// - opcode 15 streams configuration register out
// - opcode 01 stores status, optional configuration
// - opcode 68 enables block protection mode
// - opcode 35 enters four-wire, one-wire only
// - opcode F5 leaves four-wire, four-wire only
// - opcode B0 pauses running program/erase
// - opcode 30 continues paused program/erase
// - opcode B9 enters deep sleep
// - opcode AB leaves deep sleep
// - opcode C0 takes next byte as burst
// - opcode 16 reads boot register, one-wire
// - opcode 17 plus four bytes writes boot, one-wire
// - opcode 18 erases boot register, one-wire
// - four-wire mode leaves quad enable untouched
`timescale 1ns/1ps
module sfcd_decoder (
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        RST_B,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Serial pins
	input  wire logic        CS_B,
	input  wire logic        SCLK,
	input  wire logic [3:0]  SIO_IN,
	output logic      [3:0]  SIO_OUT,
	output logic      [3:0]  SIO_OE_B,
	// Program/erase engine
	input  wire logic        PE_BUSY,
	output logic             PE_PAUSE,
	output logic             PE_CONTINUE
);
	////////////////////////////////////////////////////////////////
	// Pin capture

	logic        cs_b_s;  // Synced chip select
	logic        sclk_s;  // Synced serial clock
	logic [3:0]  sio_s;   // Synced data lanes
	logic        sclk_d;  // Previous serial clock
	logic        cs_d;    // Previous chip select

	// All pins cross through two flops
	sfcd_sync #(
		.W    (6),
		.INIT (6'h20)
	) u_sync (
		.clk   (CLK),
		.rst_b (RST_B),
		.din   ({CS_B, SCLK, SIO_IN}),
		.dout  ({cs_b_s, sclk_s, sio_s})
	);

	// Edge history
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			sclk_d <= 1'b0;
			cs_d <= 1'b1;
		end else begin
			sclk_d <= sclk_s;
			cs_d <= cs_b_s;
		end
	end

	wire active = ~cs_b_s;                  // Frame open
	wire rise = active & sclk_s & ~sclk_d;  // Sample edge
	wire fall = active & ~sclk_s & sclk_d;  // Drive edge
	wire cs_rise = cs_b_s & ~cs_d;          // Frame close

	////////////////////////////////////////////////////////////////
	// State

	sfcd_pkg::sfcd_state_t state;        // Frame state
	sfcd_pkg::sfcd_flags_t flags;        // Mode flags
	logic [7:0]            status_reg;   // Status value
	logic [7:0]            cfg_reg;      // Configuration value
	logic [7:0]            burst_reg;    // Burst length
	logic [31:0]           boot_reg;     // Fast-boot value
	logic [31:0]           stage;        // Incoming data bytes
	logic [2:0]            cnt;          // Data bytes this frame
	logic [7:0]            rd_op;        // Read command in progress
	logic                  ctrl_en;      // Software decode enable
	logic                  byte_done;    // Byte strobe
	logic [7:0]            op;           // Last byte received
	logic [3:0]            tx_bits;      // Lanes from shifter

	////////////////////////////////////////////////////////////////
	// Opcode decode

	wire take = byte_done & (state == sfcd_pkg::ST_IDLE);

	// Opcodes good in either mode
	wire is_common = (op == sfcd_pkg::OP_SET_WL) | (op == sfcd_pkg::OP_CLR_WL)
		| (op == sfcd_pkg::OP_RD_STAT) | (op == sfcd_pkg::OP_RD_CFG)
		| (op == sfcd_pkg::OP_WR_SC) | (op == sfcd_pkg::OP_BP_SEL)
		| (op == sfcd_pkg::OP_PAUSE) | (op == sfcd_pkg::OP_CONT)
		| (op == sfcd_pkg::OP_SLEEP) | (op == sfcd_pkg::OP_WAKE)
		| (op == sfcd_pkg::OP_BURST);
	// Opcodes good in one-wire mode only
	wire is_single = (op == sfcd_pkg::OP_ENTER4) | (op == sfcd_pkg::OP_RD_BOOT)
		| (op == sfcd_pkg::OP_WR_BOOT) | (op == sfcd_pkg::OP_ER_BOOT);
	wire is_four = (op == sfcd_pkg::OP_EXIT4);
	// Deep sleep hears only the wake opcode
	wire mode_ok = flags.four ? (is_common | is_four) : (is_common | is_single);
	wire op_ok = ctrl_en & (flags.deep ? (op == sfcd_pkg::OP_WAKE) : mode_ok);
	wire go = take & op_ok;

	wire is_read = (op == sfcd_pkg::OP_RD_STAT) | (op == sfcd_pkg::OP_RD_CFG)
		| (op == sfcd_pkg::OP_RD_BOOT);

	////////////////////////////////////////////////////////////////
	// Frame state machine

	sfcd_pkg::sfcd_state_t next_state;

	// Pick the data phase for an accepted opcode
	always_comb begin
		next_state = state;
		if (!active) begin
			next_state = sfcd_pkg::ST_IDLE;
		end else if (take) begin
			if (!op_ok) begin
				next_state = sfcd_pkg::ST_SKIP;
			end else if (is_read) begin
				next_state = sfcd_pkg::ST_READ;
			end else begin
				case (op)
					sfcd_pkg::OP_WR_SC: begin
						next_state = sfcd_pkg::ST_WSR;
					end
					sfcd_pkg::OP_BURST: begin
						next_state = sfcd_pkg::ST_BURST;
					end
					sfcd_pkg::OP_WR_BOOT: begin
						next_state = sfcd_pkg::ST_BOOTW;
					end
					default: begin
						next_state = sfcd_pkg::ST_SKIP;
					end
				endcase
			end
		end
	end

	// State register; closing the frame always returns to idle
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			state <= sfcd_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////
	// Data byte staging

	wire collect = byte_done & ((state == sfcd_pkg::ST_WSR)
		| (state == sfcd_pkg::ST_BURST) | (state == sfcd_pkg::ST_BOOTW));

	// Count and stage bytes; count saturates to flag overruns
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			cnt <= '0;
			stage <= '0;
			rd_op <= '0;
		end else if (take) begin
			cnt <= '0;
			rd_op <= op;
		end else if (collect) begin
			stage <= {stage[23:0], op};
			cnt <= (cnt == sfcd_pkg::CNT_MAX) ? cnt : cnt + 3'h1;
		end else if (byte_done & (state == sfcd_pkg::ST_READ)) begin
			// Boot read walks four bytes, then wraps
			cnt <= (cnt == sfcd_pkg::CNT_BOOT - 3'h1) ? 3'h0 : cnt + 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////
	// Mode flags and engine strobes

	// Commands with no data act as soon as the opcode lands
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			flags <= '0;
			PE_PAUSE <= 1'b0;
			PE_CONTINUE <= 1'b0;
		end else begin
			PE_PAUSE <= 1'b0;
			PE_CONTINUE <= 1'b0;
			if (go) begin
				case (op)
					sfcd_pkg::OP_SET_WL: flags.write_permission_latch <= 1'b1;
					sfcd_pkg::OP_CLR_WL: flags.write_permission_latch <= 1'b0;
					sfcd_pkg::OP_BP_SEL: flags.bp <= 1'b1;
					sfcd_pkg::OP_ENTER4: flags.four <= 1'b1;
					sfcd_pkg::OP_EXIT4: flags.four <= 1'b0;
					sfcd_pkg::OP_SLEEP: flags.deep <= 1'b1;
					sfcd_pkg::OP_WAKE: flags.deep <= 1'b0;
					sfcd_pkg::OP_PAUSE: begin
						if (PE_BUSY & ~flags.susp) begin
							flags.susp <= 1'b1;
							PE_PAUSE <= 1'b1;
						end
					end
					sfcd_pkg::OP_CONT: begin
						if (flags.susp) begin
							flags.susp <= 1'b0;
							PE_CONTINUE <= 1'b1;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Stored values, committed when the frame closes; boot erase commits as soon as its opcode lands

	wire end_wsr = cs_rise & (state == sfcd_pkg::ST_WSR);
	wire end_burst = cs_rise & (state == sfcd_pkg::ST_BURST) & (cnt == sfcd_pkg::CNT_ONE);
	wire end_boot = cs_rise & (state == sfcd_pkg::ST_BOOTW) & (cnt == sfcd_pkg::CNT_BOOT);

	// Partial bytes never commit; the frame need not close on a byte boundary
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			status_reg <= sfcd_pkg::STAT_RST;
			cfg_reg <= sfcd_pkg::CFG_RST;
			burst_reg <= sfcd_pkg::BURST_RST;
			boot_reg <= sfcd_pkg::BOOT_ERASED;
		end else begin
			if (end_wsr & (cnt == sfcd_pkg::CNT_ONE)) begin
				status_reg <= stage[7:0];
			end else if (end_wsr & (cnt == sfcd_pkg::CNT_TWO)) begin
				status_reg <= stage[15:8];
				cfg_reg <= stage[7:0];
			end
			if (end_burst) begin
				burst_reg <= stage[7:0];
			end
			// exactly four bytes, low byte first
			if (end_boot) begin
				boot_reg <= {stage[7:0], stage[15:8], stage[23:16], stage[31:24]};
			end else if (go & (op == sfcd_pkg::OP_ER_BOOT)) begin
				boot_reg <= sfcd_pkg::BOOT_ERASED;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Read-out path

	wire [7:0] src_op = take ? op : rd_op;
	// Boot index runs one ahead: cnt still names the byte just sent
	wire [2:0] idx = take ? 3'h0 : cnt + 3'h1;
	wire [7:0] boot_byte = boot_reg[{idx[1:0], 3'h0} +: 8];
	wire [7:0] load_data = (src_op == sfcd_pkg::OP_RD_STAT) ? status_reg
		: (src_op == sfcd_pkg::OP_RD_CFG) ? cfg_reg : boot_byte;
	wire load = (go & is_read) | (byte_done & (state == sfcd_pkg::ST_READ));

	// Shared shifter for both directions
	sfcd_shift u_shift (
		.clk       (CLK),
		.rst_b     (RST_B),
		.active    (active),
		.rise      (rise),
		.fall      (fall),
		.quad      (flags.four),
		.sio       (sio_s),
		.byte_done (byte_done),
		.rx_byte   (op),
		.load      (load),
		.load_data (load_data),
		.tx_bits   (tx_bits)
	);

	// Lanes driven only in a read phase
	assign SIO_OUT = tx_bits;
	assign SIO_OE_B = (active & (state == sfcd_pkg::ST_READ))
		? (flags.four ? sfcd_pkg::OE_QUAD : sfcd_pkg::OE_SPI) : sfcd_pkg::OE_NONE;

	////////////////////////////////////////////////////////////////
	// APB slave, zero wait states

	wire hit = (PADDR == sfcd_pkg::ADDR_CTRL) | (PADDR == sfcd_pkg::ADDR_FLAGS)
		| (PADDR == sfcd_pkg::ADDR_STAT) | (PADDR == sfcd_pkg::ADDR_CFG)
		| (PADDR == sfcd_pkg::ADDR_BURST) | (PADDR == sfcd_pkg::ADDR_BOOT);
	wire setup = PSEL & ~PENABLE;
	wire wr_ctrl = PSEL & PENABLE & PWRITE & (PADDR == sfcd_pkg::ADDR_CTRL);

	// Read word, zero-extended
	wire [31:0] rd_word =
		(PADDR == sfcd_pkg::ADDR_CTRL) ? {31'h0000_0000, ctrl_en}
		: (PADDR == sfcd_pkg::ADDR_FLAGS) ? {27'h000_0000, flags}
		: (PADDR == sfcd_pkg::ADDR_STAT) ? {24'h00_0000, status_reg}
		: (PADDR == sfcd_pkg::ADDR_CFG) ? {24'h00_0000, cfg_reg}
		: (PADDR == sfcd_pkg::ADDR_BURST) ? {24'h00_0000, burst_reg}
		: (PADDR == sfcd_pkg::ADDR_BOOT) ? boot_reg : sfcd_pkg::RD_ZERO;

	// Read data captured in setup so it comes from a flop
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			PRDATA <= sfcd_pkg::RD_ZERO;
			ctrl_en <= sfcd_pkg::CTRL_EN_RST;
		end else begin
			if (setup) begin
				PRDATA <= PWRITE ? sfcd_pkg::RD_ZERO : rd_word;
			end
			// Disabling decode makes every opcode invalid
			if (wr_ctrl) begin
				ctrl_en <= PWDATA[sfcd_pkg::CTRL_EN];
			end
		end
	end

	assign PREADY = 1'b1;
	assign PSLVERR = PSEL & PENABLE & ~hit;

	////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);

	chk_latch_set: assert property (go & (op == sfcd_pkg::OP_SET_WL) |=> flags.write_permission_latch)
		else $error("latch not set");
	chk_latch_clear: assert property (go & (op == sfcd_pkg::OP_CLR_WL) |=> !flags.write_permission_latch)
		else $error("latch not cleared");
	chk_status_out: assert property (go & (op == sfcd_pkg::OP_RD_STAT) |->
		load && (load_data == status_reg) ##1 (state == sfcd_pkg::ST_READ))
		else $error("status not sent");
	chk_wsr_pair: assert property (end_wsr & (cnt == sfcd_pkg::CNT_TWO) |=>
		(cfg_reg == $past(stage[7:0])) && (status_reg == $past(stage[15:8])))
		else $error("two-byte write lost");
	chk_four_enter: assert property (take & (op == sfcd_pkg::OP_ENTER4) & ~flags.four
		& ~flags.deep & ctrl_en |=> flags.four && $stable(status_reg))
		else $error("four-wire entry wrong");
	chk_four_exit: assert property (take & (op == sfcd_pkg::OP_EXIT4) & ~flags.four
		|=> !flags.four && (state == sfcd_pkg::ST_SKIP || state == sfcd_pkg::ST_IDLE))
		else $error("exit accepted in one-wire");
	chk_pause_pulse: assert property ($rose(flags.susp) |-> PE_PAUSE ##1 !PE_PAUSE)
		else $error("pause strobe missing");
	chk_boot_erase: assert property (go & (op == sfcd_pkg::OP_ER_BOOT)
		|=> boot_reg == sfcd_pkg::BOOT_ERASED)
		else $error("boot not erased");
	chk_bad_ignored: assert property (take & ~op_ok |=> $stable(flags)
		&& $stable(boot_reg) && !PE_PAUSE && !PE_CONTINUE)
		else $error("bad opcode acted");
endmodule

/* File: sfcd_pkg.sv */
// Opcodes, register map, flag layout and state codes of the decoder
// Assumes every decoder file refers to it by sfcd_pkg::name
package sfcd_pkg;
	// Serial opcodes
	localparam logic [7:0] OP_SET_WL = 8'h06;
	localparam logic [7:0] OP_CLR_WL = 8'h04;
	localparam logic [7:0] OP_RD_STAT = 8'h05;
	localparam logic [7:0] OP_RD_CFG = 8'h15;
	localparam logic [7:0] OP_WR_SC = 8'h01;
	localparam logic [7:0] OP_BP_SEL = 8'h68;
	localparam logic [7:0] OP_ENTER4 = 8'h35;
	localparam logic [7:0] OP_EXIT4 = 8'hF5;
	localparam logic [7:0] OP_PAUSE = 8'hB0;
	localparam logic [7:0] OP_CONT = 8'h30;
	localparam logic [7:0] OP_SLEEP = 8'hB9;
	localparam logic [7:0] OP_WAKE = 8'hAB;
	localparam logic [7:0] OP_BURST = 8'hC0;
	localparam logic [7:0] OP_RD_BOOT = 8'h16;
	localparam logic [7:0] OP_WR_BOOT = 8'h17;
	localparam logic [7:0] OP_ER_BOOT = 8'h18;
	// APB byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_FLAGS = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	localparam logic [7:0] ADDR_CFG = 8'h0C;
	localparam logic [7:0] ADDR_BURST = 8'h10;
	localparam logic [7:0] ADDR_BOOT = 8'h14;
	// Control field and reset values
	localparam int CTRL_EN = 0;
	localparam logic CTRL_EN_RST = 1'b1;
	localparam logic [7:0] STAT_RST = 8'h00;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [7:0] BURST_RST = 8'h00;
	localparam logic [31:0] BOOT_ERASED = 32'hFFFF_FFFF;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;
	// Byte counts
	localparam logic [2:0] CNT_ONE = 3'h1;
	localparam logic [2:0] CNT_TWO = 3'h2;
	localparam logic [2:0] CNT_BOOT = 3'h4;
	localparam logic [2:0] CNT_MAX = 3'h7;
	localparam logic [2:0] LAST_SPI = 3'h7;
	localparam logic [2:0] LAST_QUAD = 3'h1;
	// Output enables, low means driven
	localparam logic [3:0] OE_NONE = 4'hF;
	localparam logic [3:0] OE_QUAD = 4'h0;
	localparam logic [3:0] OE_SPI = 4'hD;
	// Mode flags as one word
	typedef struct packed {
		logic deep;
		logic susp;
		logic bp;
		logic four;
		logic write_permission_latch;
	} sfcd_flags_t;
	// Frame states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_READ = 3'b001,
		ST_WSR = 3'b010,
		ST_BURST = 3'b011,
		ST_BOOTW = 3'b100,
		ST_SKIP = 3'b101
	} sfcd_state_t;
endpackage

/* File: sfcd_sync.sv */
// Two-flop synchroniser for a group of pin levels
// Assumes levels change slowly against CLK
`timescale 1ns/1ps
module sfcd_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_b,
	// Levels
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	// Width check
	if (W < 1) begin : g_chk
		$error("sfcd_sync width below one");
	end

	logic [W-1:0] meta; // First stage, read only by dout

	// Two stages
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta <= INIT;
			dout <= INIT;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule

/* File: sfcd_shift.sv */
// Byte shifter for one-wire and four-wire frames
// Assumes rise and fall are one-cycle strobes of the synced serial clock
`timescale 1ns/1ps
module sfcd_shift (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// Frame and strobes
	input  wire logic       active,
	input  wire logic       rise,
	input  wire logic       fall,
	input  wire logic       quad,
	input  wire logic [3:0] sio,
	// Receive side
	output logic            byte_done,
	output logic      [7:0] rx_byte,
	// Transmit side
	input  wire logic       load,
	input  wire logic [7:0] load_data,
	output logic      [3:0] tx_bits
);
	logic [2:0] cnt;   // Edges in this byte
	logic [7:0] sh;    // Receive shifter
	logic [7:0] tx;    // Transmit shifter
	logic       first; // Hold first bit one fall

	wire [7:0] next_sh = quad ? {sh[3:0], sio} : {sh[6:0], sio[0]};
	wire       last = (cnt == (quad ? sfcd_pkg::LAST_QUAD : sfcd_pkg::LAST_SPI));

	// Receive on rising serial edges
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= '0;
			sh <= '0;
			rx_byte <= '0;
			byte_done <= 1'b0;
		end else begin
			byte_done <= rise & last & active;
			if (!active) begin
				cnt <= '0;
			end else if (rise) begin
				sh <= next_sh;
				cnt <= last ? 3'h0 : cnt + 3'h1;
				if (last) begin
					rx_byte <= next_sh;
				end
			end
		end
	end

	// Transmit on falling edges, MSB first
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx <= '0;
			first <= 1'b0;
		end else if (load) begin
			tx <= load_data;
			first <= 1'b1;
		end else if (fall) begin
			first <= 1'b0;
			if (!first) begin
				tx <= quad ? {tx[3:0], 4'h0} : {tx[6:0], 1'b0};
			end
		end
	end

	// One-wire output sits on lane one
	assign tx_bits = quad ? tx[7:4] : {2'b00, tx[7], 1'b0};
endmodule

/* File: sfcd_host.sv */
// Serial host model: frames opcodes and data onto the flash pins
// Assumes mode 0 framing; the bench resolves shared lanes from the enables
`timescale 1ns/1ps
module sfcd_host (
	// Clock
	input  wire logic       clk,
	// Serial pins
	output logic            cs_b,
	output logic            sclk,
	output logic      [3:0] sio,
	input  wire logic [3:0] sio_out
);
	// Half period in CLK cycles, margin over pin sync and drive latency
	localparam int HALF = 6;

	////////////////////////////////////////////////////////////////////////
	// Idle levels
	initial begin
		cs_b = 1'b1;
		sclk = 1'b0;
		sio  = 4'h0;
	end

	// Wait some CLK edges
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Select, serial clock stays low outside frames
	task automatic open_frame();
		tick(1);
		cs_b <= 1'b0;
		tick(HALF);
	endtask

	// Deselect; released lanes flip so a stale level never reads back
	task automatic close_frame();
		tick(HALF);
		cs_b <= 1'b1;
		sio  <= ~sio;
		tick(8);
	endtask

	////////////////////////////////////////////////////////////////////////
	// One byte each way: drive at fall, sample at rise
	// all four lanes in four-wire
	task automatic xfer(input logic quad, input logic [7:0] tx, output logic [7:0] rx);
		int steps;
		steps = quad ? 2 : 8;
		for (int i = 0; i < steps; i++) begin
			// Unused lanes toggle, a floating line is never trusted
			if (quad) begin
				sio <= tx[7-4*i -: 4];
			end else begin
				sio <= {~sio[3:1], tx[7-i]};
			end
			tick(HALF);
			sclk <= 1'b1;
			rx = quad ? {rx[3:0], sio_out} : {rx[6:0], sio_out[1]};
			tick(HALF);
			sclk <= 1'b0;
		end
	endtask
endmodule

/* File: flash_setting_command_decoder_bench.sv */
// Self-checking bench of the setting-command decoder
// Assumes the host model drives the pins and APB reads back state
`timescale 1ns/1ps
module flash_setting_command_decoder_bench;
	// One table row: frame, then flags and one register
	typedef struct {
		logic        q;
		logic [7:0]  op;
		int          n;
		logic [31:0] dat;
		logic [4:0]  flg;
		logic [7:0]  adr;
		logic [31:0] val;
	} sfcd_row_t;

	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        cs_b;
	logic        sclk;
	logic [3:0]  host_sio;
	logic [3:0]  sio_in;
	logic [3:0]  sio_out;
	logic [3:0]  sio_oe_b;
	logic        pe_busy = 1'b0;
	logic        pe_pause;
	logic        pe_cont;
	int          error_cnt = 0;
	int          checks_done = 0;
	int          pause_n = 0;
	int          cont_n = 0;
	logic [31:0] rd;
	logic        er;

	// Lane level: device wins where its enable is low
	assign sio_in = (sio_oe_b & host_sio) | (~sio_oe_b & sio_out);

	// 20 MHz clock
	always #25 clk = ~clk;

	// Pulse widths counted in CLK cycles
	always @(posedge clk) begin
		pause_n <= pause_n + int'(pe_pause);
		cont_n  <= cont_n + int'(pe_cont);
	end

	sfcd_decoder u_sfcd_decoder (
		.CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .CS_B(cs_b), .SCLK(sclk), .SIO_IN(sio_in),
		.SIO_OUT(sio_out), .SIO_OE_B(sio_oe_b), .PE_BUSY(pe_busy),
		.PE_PAUSE(pe_pause), .PE_CONTINUE(pe_cont)
	);

	sfcd_host u_sfcd_host (
		.clk(clk), .cs_b(cs_b), .sclk(sclk), .sio(host_sio), .sio_out(sio_out)
	);

	////////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic test_done();
		$display("Checks %0d, mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Compare seen against expected
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h, expected %h", $time, seen, exp);
		end
	endtask

	// APB transfer, held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1) begin
			error_cnt++;
			test_done();
		end
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Register read and compare
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask

	// One frame; data bytes low first, read bytes wrap every four
	// host sends whole byte counts
	task automatic frame(input logic q, input logic [7:0] op, input int n,
			input logic [31:0] dat, input logic rchk);
		logic [7:0] rx;
		u_sfcd_host.open_frame();
		u_sfcd_host.xfer(q, op, rx);
		for (int k = 0; k < n; k++) begin
			u_sfcd_host.xfer(q, dat[8*(k%4) +: 8], rx);
			if (rchk) chk({24'h0, rx}, {24'h0, dat[8*(k%4) +: 8]});
		end
		if (rchk) chk({28'h0, sio_oe_b}, q ? 32'h0 : 32'hD);
		u_sfcd_host.close_frame();
		chk({28'h0, sio_oe_b}, 32'hF);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Command table, applied in order
	sfcd_row_t rows [21] = '{
		'{0, 8'h06, 0, 32'h0, 5'h01, sfcd_pkg::ADDR_STAT, 32'h0},
		'{0, 8'h04, 0, 32'h0, 5'h00, sfcd_pkg::ADDR_STAT, 32'h0},
		'{0, 8'h01, 2, 32'hA55C, 5'h00, sfcd_pkg::ADDR_STAT, 32'h5C},
		'{0, 8'h01, 1, 32'h33, 5'h00, sfcd_pkg::ADDR_CFG, 32'hA5},
		'{0, 8'h01, 3, 32'h11_2244, 5'h00, sfcd_pkg::ADDR_STAT, 32'h33},
		'{0, 8'h68, 0, 32'h0, 5'h04, sfcd_pkg::ADDR_STAT, 32'h33},
		'{0, 8'h17, 4, 32'h1234_5678, 5'h04, sfcd_pkg::ADDR_BOOT, 32'h1234_5678},
		'{0, 8'hC0, 1, 32'h09, 5'h04, sfcd_pkg::ADDR_BURST, 32'h09},
		'{0, 8'hC0, 2, 32'h0706, 5'h04, sfcd_pkg::ADDR_BURST, 32'h09},
		'{0, 8'hF5, 0, 32'h0, 5'h04, sfcd_pkg::ADDR_STAT, 32'h33},
		'{0, 8'h35, 0, 32'h0, 5'h06, sfcd_pkg::ADDR_STAT, 32'h33},
		'{1, 8'h06, 0, 32'h0, 5'h07, sfcd_pkg::ADDR_CFG, 32'hA5},
		'{1, 8'h35, 0, 32'h0, 5'h07, sfcd_pkg::ADDR_STAT, 32'h33},
		'{1, 8'h17, 4, 32'hDEAD_BEEF, 5'h07, sfcd_pkg::ADDR_BOOT, 32'h1234_5678},
		'{1, 8'h18, 0, 32'h0, 5'h07, sfcd_pkg::ADDR_BOOT, 32'h1234_5678},
		'{1, 8'h04, 0, 32'h0, 5'h06, sfcd_pkg::ADDR_STAT, 32'h33},
		'{1, 8'hF5, 0, 32'h0, 5'h04, sfcd_pkg::ADDR_STAT, 32'h33},
		'{0, 8'h18, 0, 32'h0, 5'h04, sfcd_pkg::ADDR_BOOT, 32'hFFFF_FFFF},
		'{0, 8'hB9, 0, 32'h0, 5'h14, sfcd_pkg::ADDR_STAT, 32'h33},
		'{0, 8'h06, 0, 32'h0, 5'h14, sfcd_pkg::ADDR_STAT, 32'h33},
		'{0, 8'hAB, 0, 32'h0, 5'h04, sfcd_pkg::ADDR_STAT, 32'h33}
	};

	// Hang guard
	initial begin
		repeat (90000) @(posedge clk);
		error_cnt++;
		test_done();
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		foreach (rows[i]) begin
			frame(rows[i].q, rows[i].op, rows[i].n, rows[i].dat, 1'b0);
			rdchk(sfcd_pkg::ADDR_FLAGS, {27'h0, rows[i].flg});
			rdchk(rows[i].adr, rows[i].val);
		end
		// Register reads in both modes, boot wraps after four bytes
		frame(0, 8'h05, 2, {4{8'h33}}, 1'b1);
		frame(0, 8'h15, 1, {4{8'hA5}}, 1'b1);
		frame(0, 8'h17, 4, 32'hCAFE_0142, 1'b0);
		frame(0, 8'h16, 5, 32'hCAFE_0142, 1'b1);
		frame(0, 8'h35, 0, 32'h0, 1'b0);
		frame(1, 8'h05, 1, {4{8'h33}}, 1'b1);
		frame(1, 8'h15, 1, {4{8'hA5}}, 1'b1);
		frame(1, 8'hF5, 0, 32'h0, 1'b0);
		// Pause ignored while idle, one pulse when busy, none twice
		frame(0, 8'hB0, 0, 32'h0, 1'b0);
		chk(pause_n, 0);
		@(posedge clk) pe_busy <= 1'b1;
		frame(0, 8'hB0, 0, 32'h0, 1'b0);
		frame(0, 8'hB0, 0, 32'h0, 1'b0);
		chk(pause_n, 1);
		rdchk(sfcd_pkg::ADDR_FLAGS, 32'h0C);
		frame(0, 8'h30, 0, 32'h0, 1'b0);
		frame(0, 8'h30, 0, 32'h0, 1'b0);
		chk(cont_n, 1);
		rdchk(sfcd_pkg::ADDR_FLAGS, 32'h04);
		// Decode disabled: opcode has no effect
		apb(1'b1, sfcd_pkg::ADDR_CTRL, 32'h0);
		frame(0, 8'h06, 0, 32'h0, 1'b0);
		rdchk(sfcd_pkg::ADDR_FLAGS, 32'h04);
		apb(1'b1, sfcd_pkg::ADDR_CTRL, 32'h1);
		// Read-only write dropped, unmapped access refused
		apb(1'b1, sfcd_pkg::ADDR_FLAGS, 32'h1F);
		rdchk(sfcd_pkg::ADDR_FLAGS, 32'h04);
		rdchk(8'h40, 32'h0);
		chk({31'h0, er}, 32'h1);
		// Second reset restores every value
		@(posedge clk) rst_b <= 1'b0;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		rdchk(sfcd_pkg::ADDR_CTRL, 32'h1);
		rdchk(sfcd_pkg::ADDR_FLAGS, 32'h0);
		rdchk(sfcd_pkg::ADDR_STAT, 32'h0);
		rdchk(sfcd_pkg::ADDR_CFG, 32'h0);
		rdchk(sfcd_pkg::ADDR_BURST, 32'h0);
		rdchk(sfcd_pkg::ADDR_BOOT, 32'hFFFF_FFFF);
		test_done();
	end
endmodule
